// File: hw/speed_reference_shaping_zero_clamp.v
// Speed reference shaping (ramp, lag filter) with zero clamp position hold
// Behaviour
// (RL1) Step reference becomes trapezoid: separate rise and fall rates.
// (RL2) Ramp-up time 0..10000 ms, standstill to max speed, default 0, immediate.
// (RL3) Ramp-down time 0..10000 ms, max speed to standstill, default 0, immediate.
// (RL4) Speed reference passes a first-order lag filter before speed control.
// (RL5) Lag time constant 0..65535 in 0.01 ms, default 40, immediate.
// (RL6) Host should keep default lag; large values slow response.
// (RL7) Clamp input on and reference at or below level: hold position.
// (RL8) While clamped hold within one pulse of captured position, return after push.
// (RL9) Clamp input off means no clamping at any reference.
// (RL10) Routing mode 0: fixed default pin; mode 1: pin chosen by routing field.
// (RL11) Clamping only for methods 0,3,4,5,6,7,9,A and only in speed control.
// (RL12) Methods 5,6,7,9 disable clamping whenever not in speed control.
// (RL13) Routing set always-on clamps whenever reference is at or below level.
// (RL14) Method field picks mode and inputs; applied only after restart.
// (RL15) Clamp level 0..10000, default 10, rotary and linear settings, immediate.
// (RL16) Level above max motor speed is limited to max motor speed.
// (RL17) Host tunes position loop gains if motor oscillates while clamped.
// (RL18) Commanded speed proportional to voltage; gain 150..3000 in 0.01 V.
// (RL19) Zero time makes stage transparent; ramp step is max speed over periods.
// (RL20) Clamp comparison uses reference magnitude, either polarity.
`timescale 1ns/1ps
`include "speed_shaping_consts.vh"

module speed_reference_shaping_zero_clamp #(
   parameter RAMP_TICK_CYCLES = `RAMP_TICK_DEFAULT
) (
   input  wire               clk,
   input  wire               reset,
   input  wire        [4:0]  addr,
   input  wire        [15:0] wdata,
   input  wire               wr,
   input  wire               rd,
   output reg         [15:0] rdata,
   input  wire signed [15:0] ref_voltage,
   input  wire        [6:0]  input_pins,
   input  wire               method_switch_input,
   input  wire               preset_speed_select_a,
   input  wire               preset_speed_select_b,
   input  wire               preset_direction_select,
   input  wire               gain_select,
   input  wire signed [31:0] feedback_position,
   output reg  signed [15:0] speed_command,
   output reg                clamp_active,
   output wire               speed_control_active
);

   // Settings
   reg        [15:0] ramp_up_time;
   reg        [15:0] ramp_down_time;
   reg        [15:0] reference_lag_time_constant;
   reg        [15:0] hold_threshold_rotary;
   reg        [15:0] hold_threshold_linear;
   reg        [3:0]  control_method_select;
   reg               input_routing_mode;
   reg        [3:0]  hold_input_routing;
   reg        [15:0] position_loop_gain;
   reg        [15:0] alternate_position_loop_gain;
   reg        [15:0] reference_voltage_gain;
   reg        [15:0] max_speed;
   reg        [15:0] rated_speed;
   reg               motor_linear;
   reg        [15:0] preset_speed1;
   reg        [15:0] preset_speed2;
   reg        [15:0] preset_speed3;
   reg        [3:0]  active_method;

   // Shaping and hold state
   reg  signed [23:0] ramp_value;
   reg  signed [23:0] lag_value;
   reg  signed [31:0] hold_position;
   reg         [15:0] ramp_count;
   reg         [7:0]  filter_count;

   // Limit a written value into its legal range
   function [15:0] limit;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (v < lo)
            limit = lo;
         else if (v > hi)
            limit = hi;
         else
            limit = v;
      end
   endfunction

   // Saturate a wide signed value to plus or minus a bound
   function signed [15:0] sat_speed;
      input signed [49:0] v;
      input        [15:0] bound;
      reg   signed [49:0] b;
      reg   signed [49:0] nb;
      begin
         b  = $signed({34'h0, bound});
         nb = -b;
         if (v > b)
            sat_speed = b[15:0];
         else if (v < nb)
            sat_speed = nb[15:0];
         else
            sat_speed = v[15:0];
      end
   endfunction

   // Magnitude of a signed speed
   function [15:0] mag16;
      input signed [15:0] v;
      begin
         if (v < 0)
            mag16 = -v;
         else
            mag16 = v;
      end
   endfunction

   // Analog voltage scaled to speed units
   wire signed [49:0] volt_prod     = ref_voltage * $signed({1'b0, rated_speed}); // RL18
   wire signed [49:0] analog_wide   = volt_prod / $signed({34'h0, reference_voltage_gain});
   wire signed [15:0] analog_speed  = sat_speed(analog_wide, max_speed); // RL18

   // Preset speed chosen by the select pins, zero when both are low
   reg         [15:0] preset_mag;
   always @* begin
      case ({preset_speed_select_b, preset_speed_select_a})
         2'h1:    preset_mag = preset_speed1;
         2'h2:    preset_mag = preset_speed2;
         2'h3:    preset_mag = preset_speed3;
         default: preset_mag = 16'h0000;
      endcase
   end
   wire signed [49:0] preset_wide = preset_direction_select ?
                                    -$signed({34'h0, preset_mag}) : $signed({34'h0, preset_mag});
   wire signed [15:0] preset_speed = sat_speed(preset_wide, max_speed);

   // Method decode: which source is used and whether speed control is running
   reg use_preset;
   reg speed_mode;
   always @* begin
      use_preset = 1'b0;
      speed_mode = 1'b0;
      case (active_method) // RL14
         `METHOD_ANALOG, `METHOD_ANALOG_CLAMP: begin
            speed_mode = 1'b1;
         end
         `METHOD_PRESET: begin
            speed_mode = 1'b1;
            use_preset = 1'b1;
         end
         `METHOD_PRESET_ANALOG: begin
            speed_mode = 1'b1;
            use_preset = ~method_switch_input;
         end
         `METHOD_PRESET_POSITION, `METHOD_PRESET_TORQUE: begin
            speed_mode = ~method_switch_input; // RL12
            use_preset = 1'b1;
         end
         `METHOD_POSITION_SPEED, `METHOD_TORQUE_SPEED: begin
            speed_mode = method_switch_input; // RL12
         end
         default: speed_mode = 1'b0; // RL11
      endcase
   end
   assign speed_control_active = speed_mode;
   wire signed [15:0] target_speed = use_preset ? preset_speed : analog_speed;

   // Clamp input as routed; codes above the always-on value never assert
   wire hold_position_input = input_routing_mode ? // RL10
                              ((hold_input_routing < `HOLD_ALWAYS_ON) ?
                               input_pins[hold_input_routing[2:0]] :
                               (hold_input_routing == `HOLD_ALWAYS_ON)) : // RL13
                              input_pins[`HOLD_DEFAULT_PIN]; // RL10

   // Effective level, never above max speed
   wire [15:0] level_raw  = motor_linear ? hold_threshold_linear : hold_threshold_rotary; // RL15
   wire [15:0] level_eff  = (level_raw > max_speed) ? max_speed : level_raw; // RL16
   wire        below_level = (mag16(target_speed) <= level_eff); // RL20
   wire        clamp_req  = speed_mode & hold_position_input & below_level; // RL7 RL9 RL11

   // Ramp rates per 1 ms period in 16.8 fixed point
   wire [23:0] full_scale = {max_speed, 8'h00};
   wire [23:0] up_step    = (ramp_up_time == 16'h0000) ? 24'h000000 :
                            full_scale / {8'h00, ramp_up_time}; // RL19
   wire [23:0] down_step  = (ramp_down_time == 16'h0000) ? 24'h000000 :
                            full_scale / {8'h00, ramp_down_time}; // RL19
   wire signed [23:0] target_fx = {target_speed, 8'h00};
   wire accel = ((ramp_value >= 0) && (target_fx > ramp_value)) ||
                ((ramp_value <= 0) && (target_fx < ramp_value)); // RL1
   wire [15:0] ramp_time = accel ? ramp_up_time : ramp_down_time;
   wire signed [24:0] ramp_step = $signed({1'b0, (accel ? up_step : down_step)});
   wire signed [24:0] ramp_gap  = {target_fx[23], target_fx} - {ramp_value[23], ramp_value};
   wire ramp_tick   = (ramp_count == RAMP_TICK_CYCLES[15:0] - 16'h0001);
   wire filter_tick = (filter_count == `FILTER_TICK_CYCLES - 8'h01);

   // Next ramp value: at most one step toward the target per tick, straight to it when the ramp time is zero
   reg signed [23:0] next_ramp;
   always @* begin
      next_ramp = ramp_value;
      if (ramp_time == 16'h0000)
         next_ramp = target_fx; // RL19
      else if (ramp_tick) begin
         if (ramp_gap > ramp_step)
            next_ramp = ramp_value + ramp_step[23:0]; // RL2 RL3
         else if (ramp_gap < -ramp_step)
            next_ramp = ramp_value - ramp_step[23:0]; // RL2 RL3
         else
            next_ramp = target_fx;
      end
   end

   // Lag filter: each 10 us moves by the gap over the time constant
   wire signed [24:0] lag_gap  = {next_ramp[23], next_ramp} - {lag_value[23], lag_value};
   wire signed [24:0] lag_move = lag_gap / $signed({9'h000, reference_lag_time_constant});
   reg  signed [23:0] next_lag;
   always @* begin
      next_lag = lag_value;
      if (reference_lag_time_constant == 16'h0000)
         next_lag = next_ramp; // RL19
      else if (filter_tick)
         next_lag = lag_value + lag_move[23:0]; // RL4 RL5
   end

   // Position loop while clamped; dead zone of one feedback pulse
   wire signed [31:0] pos_error = hold_position - feedback_position;
   wire        [15:0] pos_gain  = gain_select ? alternate_position_loop_gain : position_loop_gain;
   wire signed [49:0] pos_prod  = {{18{pos_error[31]}}, pos_error} * $signed({34'h0, pos_gain});
   wire signed [49:0] pos_scaled = pos_prod >>> `POS_GAIN_SHIFT;
   wire        in_band  = (pos_error >= -32'sd1) && (pos_error <= 32'sd1); // RL8
   wire signed [15:0] hold_cmd = in_band ? 16'h0000 : sat_speed(pos_scaled, max_speed); // RL8

   // Ramp, filter and tick counters
   always @(posedge clk) begin
      if (reset) begin
         ramp_value   <= 24'h000000;
         lag_value    <= 24'h000000;
         ramp_count   <= 16'h0000;
         filter_count <= 8'h00;
      end else begin
         ramp_value   <= next_ramp;
         lag_value    <= next_lag;
         ramp_count   <= ramp_tick ? 16'h0000 : ramp_count + 16'h0001;
         filter_count <= filter_tick ? 8'h00 : filter_count + 8'h01;
      end
   end

   // Clamp state and command; position captured on entry only
   always @(posedge clk) begin
      if (reset) begin
         clamp_active  <= 1'b0;
         hold_position <= 32'h00000000;
         speed_command <= 16'h0000;
      end else begin
         clamp_active <= clamp_req; // RL7
         if (clamp_req && !clamp_active)
            hold_position <= feedback_position; // RL8
         if (clamp_active)
            speed_command <= hold_cmd; // RL7 RL8
         else if (speed_mode)
            speed_command <= lag_value[23:8];
         else
            speed_command <= 16'h0000;
      end
   end

   // Register writes; out-of-range values are pulled to the nearest limit
   always @(posedge clk) begin
      if (reset) begin
         ramp_up_time                 <= `RAMP_TIME_RESET;
         ramp_down_time               <= `RAMP_TIME_RESET;
         reference_lag_time_constant  <= `LAG_TIME_RESET;
         hold_threshold_rotary        <= `HOLD_THR_RESET;
         hold_threshold_linear        <= `HOLD_THR_RESET;
         control_method_select        <= `METHOD_ANALOG;
         input_routing_mode           <= 1'b0;
         hold_input_routing           <= 4'h0;
         position_loop_gain           <= `POS_GAIN_RESET;
         alternate_position_loop_gain <= `POS_GAIN_RESET;
         reference_voltage_gain       <= `VOLTAGE_GAIN_RESET;
         max_speed                    <= `MAX_SPEED_RESET;
         rated_speed                  <= `RATED_SPEED_RESET;
         motor_linear                 <= 1'b0;
         preset_speed1                <= 16'h0000;
         preset_speed2                <= 16'h0000;
         preset_speed3                <= 16'h0000;
         active_method                <= `METHOD_ANALOG;
      end else if (wr) begin
         case (addr)
            `RAMP_UP_TIME_ADDR:
               ramp_up_time <= limit(wdata, 16'h0000, `RAMP_TIME_MAX); // RL2
            `RAMP_DOWN_TIME_ADDR:
               ramp_down_time <= limit(wdata, 16'h0000, `RAMP_TIME_MAX); // RL3
            `LAG_TIME_CONSTANT_ADDR:
               reference_lag_time_constant <= wdata; // RL5
            `HOLD_THR_ROTARY_ADDR:
               hold_threshold_rotary <= limit(wdata, 16'h0000, `HOLD_THR_MAX); // RL15
            `HOLD_THR_LINEAR_ADDR:
               hold_threshold_linear <= limit(wdata, 16'h0000, `HOLD_THR_MAX); // RL15
            `CONTROL_METHOD_ADDR:
               control_method_select <= wdata[3:0];
            `INPUT_ROUTING_MODE_ADDR:
               input_routing_mode <= wdata[0];
            `HOLD_INPUT_ROUTING_ADDR:
               hold_input_routing <= wdata[3:0];
            `POS_LOOP_GAIN_ADDR:
               position_loop_gain <= wdata;
            `ALT_POS_LOOP_GAIN_ADDR:
               alternate_position_loop_gain <= wdata;
            `VOLTAGE_GAIN_ADDR:
               reference_voltage_gain <= limit(wdata, `VOLTAGE_GAIN_MIN,
                                               `VOLTAGE_GAIN_MAX); // RL18
            `MAX_SPEED_ADDR:
               max_speed <= limit(wdata, 16'h0001, `MAX_SPEED_MAX);
            `RATED_SPEED_ADDR:
               rated_speed <= limit(wdata, 16'h0000, `MAX_SPEED_MAX);
            `MOTOR_CONFIG_ADDR:
               motor_linear <= wdata[0];
            `PRESET_SPEED1_ADDR:
               preset_speed1 <= wdata;
            `PRESET_SPEED2_ADDR:
               preset_speed2 <= wdata;
            `PRESET_SPEED3_ADDR:
               preset_speed3 <= wdata;
            // Method changes mid-run would jump sources, so they wait here
            `RESTART_ADDR:
               if (wdata[0])
                  active_method <= control_method_select; // RL14
            default:
               active_method <= active_method;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise and when unmapped
   always @(posedge clk) begin
      if (reset)
         rdata <= 16'h0000;
      else if (rd) begin
         case (addr)
            `RAMP_UP_TIME_ADDR:       rdata <= ramp_up_time;
            `RAMP_DOWN_TIME_ADDR:     rdata <= ramp_down_time;
            `LAG_TIME_CONSTANT_ADDR:  rdata <= reference_lag_time_constant;
            `HOLD_THR_ROTARY_ADDR:    rdata <= hold_threshold_rotary;
            `HOLD_THR_LINEAR_ADDR:    rdata <= hold_threshold_linear;
            `CONTROL_METHOD_ADDR:     rdata <= {12'h000, control_method_select};
            `INPUT_ROUTING_MODE_ADDR: rdata <= {15'h0000, input_routing_mode};
            `HOLD_INPUT_ROUTING_ADDR: rdata <= {12'h000, hold_input_routing};
            `POS_LOOP_GAIN_ADDR:      rdata <= position_loop_gain;
            `ALT_POS_LOOP_GAIN_ADDR:  rdata <= alternate_position_loop_gain;
            `VOLTAGE_GAIN_ADDR:       rdata <= reference_voltage_gain;
            `MAX_SPEED_ADDR:          rdata <= max_speed;
            `RATED_SPEED_ADDR:        rdata <= rated_speed;
            `MOTOR_CONFIG_ADDR:       rdata <= {15'h0000, motor_linear};
            `PRESET_SPEED1_ADDR:      rdata <= preset_speed1;
            `PRESET_SPEED2_ADDR:      rdata <= preset_speed2;
            `PRESET_SPEED3_ADDR:      rdata <= preset_speed3;
            `STATUS_ADDR:             rdata <= {12'h000, below_level, hold_position_input,
                                                speed_mode, clamp_active};
            `SPEED_COMMAND_ADDR:      rdata <= speed_command;
            `ACTIVE_METHOD_ADDR:      rdata <= {12'h000, active_method};
            `POSITION_ERROR_ADDR:     rdata <= pos_error[15:0];
            default:                  rdata <= 16'h0000;
         endcase
      end else
         rdata <= 16'h0000;
   end
endmodule

// File: include/speed_shaping_consts.vh
// Constants for the speed reference shaping and zero clamp block
`ifndef SPEED_SHAPING_CONSTS_VH
`define SPEED_SHAPING_CONSTS_VH

// Register word addresses
`define RAMP_UP_TIME_ADDR        5'h00
`define RAMP_DOWN_TIME_ADDR      5'h01
`define LAG_TIME_CONSTANT_ADDR   5'h02
`define HOLD_THR_ROTARY_ADDR     5'h03
`define HOLD_THR_LINEAR_ADDR     5'h04
`define CONTROL_METHOD_ADDR      5'h05
`define INPUT_ROUTING_MODE_ADDR  5'h06
`define HOLD_INPUT_ROUTING_ADDR  5'h07
`define POS_LOOP_GAIN_ADDR       5'h08
`define ALT_POS_LOOP_GAIN_ADDR   5'h09
`define VOLTAGE_GAIN_ADDR        5'h0A
`define MAX_SPEED_ADDR           5'h0B
`define RATED_SPEED_ADDR         5'h0C
`define MOTOR_CONFIG_ADDR        5'h0D
`define PRESET_SPEED1_ADDR       5'h0E
`define PRESET_SPEED2_ADDR       5'h0F
`define PRESET_SPEED3_ADDR       5'h10
`define RESTART_ADDR             5'h11
`define STATUS_ADDR              5'h12
`define SPEED_COMMAND_ADDR       5'h13
`define ACTIVE_METHOD_ADDR       5'h14
`define POSITION_ERROR_ADDR      5'h15

// Status bit positions
`define STATUS_CLAMPED_BIT       0
`define STATUS_SPEED_CTL_BIT     1
`define STATUS_HOLD_INPUT_BIT    2
`define STATUS_BELOW_LEVEL_BIT   3

// Reset values and ranges
`define RAMP_TIME_RESET          16'h0000
`define RAMP_TIME_MAX            16'h2710
`define LAG_TIME_RESET           16'h0028
`define HOLD_THR_RESET           16'h000A
`define HOLD_THR_MAX             16'h2710
`define VOLTAGE_GAIN_RESET       16'h0258
`define VOLTAGE_GAIN_MIN         16'h0096
`define VOLTAGE_GAIN_MAX         16'h0BB8
`define POS_GAIN_RESET           16'h0190
`define MAX_SPEED_RESET          16'h1770
`define MAX_SPEED_MAX            16'h7530
`define RATED_SPEED_RESET        16'h0BB8
`define POS_GAIN_SHIFT           8
`define HOLD_DEFAULT_PIN         3'h0
`define HOLD_ALWAYS_ON           4'h7

// Control method codes
`define METHOD_ANALOG            4'h0
`define METHOD_PRESET            4'h3
`define METHOD_PRESET_ANALOG     4'h4
`define METHOD_PRESET_POSITION   4'h5
`define METHOD_PRESET_TORQUE     4'h6
`define METHOD_POSITION_SPEED    4'h7
`define METHOD_TORQUE_SPEED      4'h9
`define METHOD_ANALOG_CLAMP      4'hA

// Timing
`define CLK_PERIOD_NS            50
`define RAMP_PERIOD_NS           1000000
`define FILTER_PERIOD_NS         10000
`define RAMP_TICK_DEFAULT        (`RAMP_PERIOD_NS / `CLK_PERIOD_NS)
`define FILTER_TICK_CYCLES       (`FILTER_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// File: sim/shaping_checker_properties.sv
// Port checker for the speed shaping and zero clamp block
`timescale 1ns/1ps
`include "speed_shaping_consts.vh"
module shaping_checker (
   input wire               clk,
   input wire               reset,
   input wire        [4:0]  addr,
   input wire               wr,
   input wire               rd,
   input wire        [15:0] rdata,
   input wire               method_switch_input,
   input wire signed [31:0] feedback_position,
   input wire signed [15:0] speed_command,
   input wire               clamp_active,
   input wire               speed_control_active
);
   reg                clamp_d;
   reg                restart_d;
   reg signed  [31:0] fb_d;
   reg signed  [31:0] hold;
   wire signed [31:0] err = feedback_position - hold;

   // Own copy of the captured position, taken one edge after the hold engages, from the delayed feedback
   always @(posedge clk) begin
      clamp_d   <= clamp_active;
      restart_d <= wr && (addr == `RESTART_ADDR);
      fb_d      <= feedback_position;
      if (clamp_active && !clamp_d) begin
         hold <= fb_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // First cycle after engage is skipped: the copy is not yet valid there
   sequence near_s; clamp_active && clamp_d && err >= -1 && err <= 1; endsequence
   sequence ahead_s; clamp_active && clamp_d && err > 1; endsequence
   sequence behind_s; clamp_active && clamp_d && err < -1; endsequence

   a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside its slot");
   a_mode_drops_hold: assert property (!speed_control_active |=> !clamp_active)
      else $error("hold kept outside speed control");
   a_hold_needs_mode: assert property ($rose(clamp_active) |-> $past(speed_control_active))
      else $error("hold engaged outside speed control");
   a_hold_quiet_zero: assert property (near_s [*3] |-> speed_command == 16'sh0000)
      else $error("drive while within one count");
   a_push_back_neg: assert property (ahead_s [*3] |-> speed_command < 16'sh0000)
      else $error("no reverse drive after push");
   a_push_back_pos: assert property (behind_s [*3] |-> speed_command > 16'sh0000)
      else $error("no forward drive after push");
   a_method_on_restart: assert property ($changed(speed_control_active) |->
      $changed(method_switch_input) || restart_d)
      else $error("mode changed without cause");
   a_off_mode_still: assert property ((!speed_control_active) [*3] |->
      speed_command == 16'sh0000)
      else $error("speed output outside speed control");
endmodule

bind speed_reference_shaping_zero_clamp shaping_checker chk (
   .clk(clk), .reset(reset), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
   .method_switch_input(method_switch_input), .feedback_position(feedback_position),
   .speed_command(speed_command), .clamp_active(clamp_active),
   .speed_control_active(speed_control_active));

// File: sim/host_ctrl_model.sv
// Host controller model driving the analog reference and digital inputs
`timescale 1ns/1ps
module host_ctrl_model (
   input  wire               clk,
   input  wire signed [15:0] target,
   input  wire        [6:0]  pins_req,
   output reg  signed [15:0] ref_voltage = 16'sh0000,
   output reg         [6:0]  input_pins = 7'h00
);
   // Outputs move one edge after a request, like a sampled DAC and relay bank
   always @(posedge clk) begin
      ref_voltage <= target;
      input_pins  <= pins_req;
   end
endmodule

// File: sim/test_speed_reference_shaping_zero_clamp.sv
// Self-checking bench for the speed shaping and zero clamp block
`timescale 1ns/1ps
`include "speed_shaping_consts.vh"
module test_speed_reference_shaping_zero_clamp;
   localparam [10:0] M0 = 11'h479;
   localparam [10:0] M1 = 11'h699;
   reg                clk, reset, wr, rd, msw, gsel;
   reg         [4:0]  addr;
   reg         [15:0] wdata;
   reg         [2:0]  psel;
   reg         [6:0]  pins;
   reg  signed [15:0] target;
   reg  signed [31:0] fb;
   wire        [15:0] rdata;
   wire signed [15:0] vref, spd;
   wire        [6:0]  ipins;
   wire               clamp, smode;
   integer            n_fail, num_checks, i, j;

   host_ctrl_model HOST (.clk(clk), .target(target), .pins_req(pins),
      .ref_voltage(vref), .input_pins(ipins));
   speed_reference_shaping_zero_clamp #(.RAMP_TICK_CYCLES(20)) DUT (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ref_voltage(vref), .input_pins(ipins), .method_switch_input(msw),
      .preset_speed_select_a(psel[0]), .preset_speed_select_b(psel[1]),
      .preset_direction_select(psel[2]), .gain_select(gsel), .feedback_position(fb),
      .speed_command(spd), .clamp_active(clamp), .speed_control_active(smode));

   task chk16(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
         end
      end
   endtask
   task chk1(input got, input exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
         end
      end
   endtask
   // Every bus task starts on an edge so drives never race the sampling edge
   task wreg(input [4:0] a, input [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rreg(input [4:0] a, input [15:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         chk16(rdata, exp);
      end
   endtask
   task wait_n(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task step_ref(input [15:0] v, input [15:0] exp);
      begin
         @(posedge clk);
         target <= v;
         wait_n(6);
         chk16(spd, exp);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d failures %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask

   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard, well above the expected run length
   initial begin
      #(40000 * 50);
      n_fail = n_fail + 1;
      end_sim;
   end

   initial begin
      n_fail = 0; num_checks = 0; reset = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00;
      wdata = 16'h0000; msw = 1'b0; gsel = 1'b0; psel = 3'h0; pins = 7'h00;
      target = 16'sh0000; fb = 1000;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      wait_n(1);
      chk1(clamp, 1'b0);
      rreg(`RAMP_UP_TIME_ADDR, 16'h0000);
      rreg(`RAMP_DOWN_TIME_ADDR, 16'h0000);
      rreg(`LAG_TIME_CONSTANT_ADDR, 16'h0028);
      rreg(`HOLD_THR_ROTARY_ADDR, 16'h000A);
      rreg(`VOLTAGE_GAIN_ADDR, 16'h0258);
      rreg(5'h1F, 16'h0000);
      wreg(`RAMP_UP_TIME_ADDR, 16'hFFFF);
      rreg(`RAMP_UP_TIME_ADDR, 16'h2710);
      wreg(`HOLD_THR_ROTARY_ADDR, 16'hFFFF);
      rreg(`HOLD_THR_ROTARY_ADDR, 16'h2710);
      wreg(`HOLD_THR_ROTARY_ADDR, 16'h000A);
      wreg(`RAMP_UP_TIME_ADDR, 16'h0000);
      wreg(`LAG_TIME_CONSTANT_ADDR, 16'h0000);
      step_ref(16'd600, 16'd3000);
      step_ref(-16'sd300, -16'sd1500);
      step_ref(16'd100, 16'd500);
      step_ref(16'd0, 16'd0);
      // Ramp: 10 periods up, 20 periods down (20 clocks each here), so the fall must be visibly slower
      wreg(`RAMP_UP_TIME_ADDR, 16'h000A);
      wreg(`RAMP_DOWN_TIME_ADDR, 16'h0014);
      step_ref(16'd600, 16'd0);
      wait_n(54);
      chk1(spd > 16'sh0000 && spd < 16'sd3000, 1'b1);
      wait_n(200);
      chk16(spd, 16'd3000);
      @(posedge clk);
      target <= 16'sh0000;
      wait_n(150);
      chk1(spd > 16'sh0000 && spd < 16'sd3000, 1'b1);
      wait_n(150);
      chk16(spd, 16'd0);
      wreg(`RAMP_UP_TIME_ADDR, 16'h0000);
      wreg(`RAMP_DOWN_TIME_ADDR, 16'h0000);
      step_ref(16'd600, 16'd3000);
      step_ref(16'd0, 16'd0);
      // Lag of four filter ticks: partial after two, near target later
      wreg(`LAG_TIME_CONSTANT_ADDR, 16'h0004);
      step_ref(16'd600, 16'd0);
      wait_n(400);
      chk1(spd > 16'sh0000 && spd < 16'sd3000, 1'b1);
      wait_n(8000);
      chk1(spd > 16'sd2900, 1'b1);
      wreg(`LAG_TIME_CONSTANT_ADDR, 16'h0000);
      step_ref(16'd0, 16'd0);
      @(posedge clk);
      pins <= 7'h01;
      step_ref(16'd2, 16'd0);
      chk1(clamp, 1'b1);
      @(posedge clk);
      fb <= 1005;
      wait_n(6);
      chk1(spd < 16'sh0000, 1'b1);
      wreg(`ALT_POS_LOOP_GAIN_ADDR, 16'h0800);
      gsel <= 1'b1;
      wait_n(4);
      chk16(spd, -16'sd40);
      @(posedge clk);
      fb <= 995;
      wait_n(6);
      chk1(spd > 16'sh0000, 1'b1);
      @(posedge clk);
      fb <= 1001;
      step_ref(-16'sd2, 16'd0);
      chk1(clamp, 1'b1);
      step_ref(16'd3, 16'd15);
      chk1(clamp, 1'b0);
      wreg(`MOTOR_CONFIG_ADDR, 16'h0001);
      wreg(`HOLD_THR_LINEAR_ADDR, 16'h0014);
      wait_n(4);
      chk1(clamp, 1'b1);
      @(posedge clk);
      pins <= 7'h00;
      step_ref(16'd0, 16'd0);
      chk1(clamp, 1'b0);
      wreg(`INPUT_ROUTING_MODE_ADDR, 16'h0001);
      wreg(`HOLD_INPUT_ROUTING_ADDR, 16'h0003);
      @(posedge clk);
      pins <= 7'h01;
      wait_n(6);
      chk1(clamp, 1'b0);
      @(posedge clk);
      pins <= 7'h08;
      wait_n(6);
      chk1(clamp, 1'b1);
      wreg(`HOLD_INPUT_ROUTING_ADDR, 16'h0007);
      @(posedge clk);
      pins <= 7'h00;
      wait_n(6);
      chk1(clamp, 1'b1);
      wreg(`CONTROL_METHOD_ADDR, 16'h0001);
      wait_n(4);
      chk1(smode, 1'b1);
      // Method codes 0 to 10 except 8, each with both states of the method-select input
      for (i = 0; i < 11; i = i + 1) begin
         if (i != 8) begin
            wreg(`CONTROL_METHOD_ADDR, i[15:0]);
            wreg(`RESTART_ADDR, 16'h0001);
            for (j = 0; j < 2; j = j + 1) begin
               @(posedge clk);
               msw <= j[0];
               wait_n(4);
               chk1(smode, j ? M1[i] : M0[i]);
               chk1(clamp, j ? M1[i] : M0[i]);
            end
         end
      end
      end_sim;
   end
endmodule
